// [logic/rcw_pkg.sv]
// Shared constants and types for the reset, configuration and watchdog unit.
package rcw_pkg;

  // Core clock.
  localparam real CLK_PERIOD_NS = 4.0;

  // Reset delay timer and watchdog times, as printed, and their cycle counts.
  localparam real DRT_POR_TIME_MS  = 1.125;
  localparam real DRT_SUB_TIME_US  = 10.0;
  localparam real WDOG_BASE_TIME_MS = 18.0;
  localparam int  DRT_POR_CYCLES   = int'(DRT_POR_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  DRT_SUB_CYCLES   = int'(DRT_SUB_TIME_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int  WDOG_BASE_CYCLES = int'(WDOG_BASE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  DRT_CNT_W        = 20;
  localparam int  WDOG_CNT_W       = 24;
  localparam int  PRESCALE_W       = 7;
  localparam int  RATIO_W          = 3;

  // Configuration word layout.
  localparam int          CFG_W          = 12;
  localparam int          CFG_IMPL_W     = 5;
  localparam int          CFG_EXT_RST    = 4;
  localparam int          CFG_CODE_PROT  = 3;
  localparam int          CFG_WDOG_EN    = 2;
  localparam int          CFG_PULLUP_N   = 1;
  localparam int          CFG_OSC_FREQ   = 0;
  localparam logic [4:0]  CFG_ERASED     = 5'h1f;

  // Register addresses on the core register port.
  localparam logic [7:0] ADDR_STATUS    = 8'h03;
  localparam logic [7:0] ADDR_OSC_TRIM  = 8'h05;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h07;

  // Status register fields.
  localparam int         ST_PIN_WAKE    = 7;
  localparam int         ST_TIMEOUT_N   = 4;
  localparam int         ST_PWRDOWN_N   = 3;
  localparam logic [7:0] STATUS_SW_MASK = 8'he7;

  // Prescale option register fields.
  localparam int         OPT_PSA        = 3;
  localparam int         OPT_RATIO_LSB  = 0;

  // Reset values.
  localparam logic [7:0] OSC_TRIM_POR   = 8'hfe;
  localparam logic [7:0] CONV_CTRL_RST  = 8'hcc;
  localparam logic [7:0] CONV_CTRL_MASK = 8'hcf;
  localparam logic [7:0] OPTION_RST     = 8'hff;
  localparam logic [7:0] PC_LOW_RST     = 8'hff;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
  localparam logic [7:0] ACCUM_CAL_MASK = 8'hfc;

  // Program memory read-out window.
  localparam logic [7:0] PROG_OPEN_LIMIT = 8'h40;
  localparam logic [7:0] PROG_LAST_ADDR  = 8'hff;

  typedef enum logic [1:0] {
    st_hold,
    st_run,
    st_sleep
  } cpu_state_t;

endpackage

// [logic/reset_delay_timer.sv]
// Device reset delay timer: holds the core in reset for a long or short delay.
`timescale 1ns/1ps
module reset_delay_timer #(
  parameter int POR_CYCLES = rcw_pkg::DRT_POR_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_start,
  input  wire logic i_hold,
  output logic      o_active
);

  logic                          long_q;
  logic [rcw_pkg::DRT_CNT_W-1:0] cnt_q;
  logic [rcw_pkg::DRT_CNT_W-1:0] limit;

  // Power-on uses the long delay, any later reset the short one.
  assign limit = long_q ? rcw_pkg::DRT_CNT_W'(POR_CYCLES - 1)
                        : rcw_pkg::DRT_CNT_W'(rcw_pkg::DRT_SUB_CYCLES - 1);

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      long_q <= 1'b1;
    end else if (i_start) begin
      long_q <= 1'b0;
    end
  end

  // Counting waits while the reset input is low, so the delay runs from its release.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_start) begin
      cnt_q    <= '0;
      o_active <= 1'b1;
    end else if (o_active) begin
      if (i_hold) begin
        cnt_q <= '0;
      end else if (cnt_q == limit) begin
        o_active <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// [logic/watchdog_timer.sv]
// Watchdog timer with an optional power-of-two prescaler.
`timescale 1ns/1ps
module watchdog_timer #(
  parameter int BASE_CYCLES = rcw_pkg::WDOG_BASE_CYCLES
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_srst,
  input  wire logic                        i_enable,
  input  wire logic                        i_clear,
  input  wire logic                        i_psa,
  input  wire logic [rcw_pkg::RATIO_W-1:0] i_ratio,
  output logic                             o_timeout
);

  logic [rcw_pkg::WDOG_CNT_W-1:0] base_q;
  logic [rcw_pkg::PRESCALE_W-1:0] pre_q;
  logic [rcw_pkg::PRESCALE_W-1:0] pre_mask;
  logic                           base_end;

  // Mask of 2^ratio - 1 selects the prescaler end count.
  for (genvar b = 0; b < rcw_pkg::PRESCALE_W; b++) begin : g_mask
    assign pre_mask[b] = (b < int'(i_ratio));
  end

  assign base_end = (base_q == rcw_pkg::WDOG_CNT_W'(BASE_CYCLES - 1));

  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_clear || !i_enable) begin
      base_q    <= '0;
      pre_q     <= '0;
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= 1'b0;
      if (base_end) begin
        base_q <= '0;
        if (!i_psa || pre_q == pre_mask) begin
          pre_q     <= '0;
          o_timeout <= 1'b1;
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end else begin
        base_q <= base_q + 1'b1;
      end
    end
  end

endmodule

// [logic/reset_config_watchdog_unit.sv]
// Reset, configuration and watchdog unit of the core.
`timescale 1ns/1ps
module reset_config_watchdog_unit #(
  parameter int DRT_POR_CYCLES   = rcw_pkg::DRT_POR_CYCLES,
  parameter int WDOG_BASE_CYCLES = rcw_pkg::WDOG_BASE_CYCLES
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_shared_input_pin,
  input  wire logic                      i_sleep_instr,
  input  wire logic                      i_wdog_clear_instr,
  input  wire logic                      i_pin_change,
  input  wire logic                      i_reg_wr,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  output logic [7:0]                     o_reg_rdata,
  input  wire logic                      i_option_wr,
  input  wire logic [7:0]                i_option_wdata,
  input  wire logic                      i_prog_cfg_wr,
  input  wire logic [rcw_pkg::CFG_W-1:0] i_prog_cfg_wdata,
  output logic [rcw_pkg::CFG_W-1:0]      o_prog_cfg_rdata,
  input  wire logic [7:0]                i_prog_rd_addr,
  output logic                           o_prog_rd_allowed,
  input  wire logic [7:0]                i_cal_literal,
  output logic                           o_cpu_reset,
  output logic                           o_regs_reset,
  output logic [7:0]                     o_pc_low,
  output logic                           o_pc_load,
  output logic [7:0]                     o_accum_value,
  output logic                           o_accum_load,
  output logic [7:0]                     o_status,
  output logic [7:0]                     o_osc_trim,
  output logic [7:0]                     o_option,
  output logic [7:0]                     o_conv_ctrl,
  output logic                           o_osc_8mhz_sel,
  output logic                           o_osc_driver_on,
  output logic                           o_shared_pin_is_gpio,
  output logic                           o_ext_reset_pullup_en,
  output logic                           o_code_protect_on,
  output logic                           o_wdog_enabled
);

  rcw_pkg::cpu_state_t                  state_q;
  logic [rcw_pkg::CFG_IMPL_W-1:0]       cfg_q;
  logic [7:0]                           status_q;
  logic [7:0]                           trim_q;
  logic [7:0]                           option_q;
  logic [7:0]                           conv_q;
  logic                                 ext_reset_in_n;
  logic                                 ext_low;
  logic                                 wdog_timeout;
  logic                                 pin_wake;
  logic                                 reset_evt;
  logic                                 resume;
  logic                                 drt_active;
  logic                                 release_now;
  logic                                 wdog_clear;
  logic                                 in_sleep;
  logic                                 in_run;
  logic                                 sw_wr_status;
  logic                                 sw_wr_trim;
  logic                                 sw_wr_conv;

  // Pin function and configuration-derived controls.
  assign ext_reset_in_n        = cfg_q[rcw_pkg::CFG_EXT_RST] ? i_shared_input_pin : 1'b1;
  assign ext_low               = !ext_reset_in_n;
  assign o_shared_pin_is_gpio  = !cfg_q[rcw_pkg::CFG_EXT_RST];
  assign o_ext_reset_pullup_en = cfg_q[rcw_pkg::CFG_EXT_RST]
                               & !cfg_q[rcw_pkg::CFG_PULLUP_N];
  assign o_code_protect_on     = !cfg_q[rcw_pkg::CFG_CODE_PROT];
  assign o_wdog_enabled        = cfg_q[rcw_pkg::CFG_WDOG_EN];
  assign o_osc_8mhz_sel        = cfg_q[rcw_pkg::CFG_OSC_FREQ];

  assign in_sleep  = (state_q == rcw_pkg::st_sleep);
  assign in_run    = (state_q == rcw_pkg::st_run);
  assign pin_wake  = in_sleep && i_pin_change;
  assign reset_evt = (in_run || in_sleep) && (ext_low || wdog_timeout || pin_wake);
  assign resume    = in_sleep && (ext_low || wdog_timeout);
  assign release_now = (state_q == rcw_pkg::st_hold) && !drt_active && !ext_low;

  // Sleep entry, wake and any held reset all restart the watchdog count.
  assign wdog_clear = i_wdog_clear_instr && in_run
                    || i_sleep_instr && in_run
                    || reset_evt
                    || (state_q == rcw_pkg::st_hold);

  assign sw_wr_status = i_reg_wr && in_run && (i_reg_addr == rcw_pkg::ADDR_STATUS);
  assign sw_wr_trim   = i_reg_wr && in_run && (i_reg_addr == rcw_pkg::ADDR_OSC_TRIM);
  assign sw_wr_conv   = i_reg_wr && in_run && (i_reg_addr == rcw_pkg::ADDR_CONV_CTRL);

  reset_delay_timer #(
    .POR_CYCLES (DRT_POR_CYCLES)
  ) u_drt (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_start    (reset_evt),
    .i_hold     (ext_low),
    .o_active   (drt_active)
  );

  watchdog_timer #(
    .BASE_CYCLES (WDOG_BASE_CYCLES)
  ) u_wdog (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_enable   (cfg_q[rcw_pkg::CFG_WDOG_EN]),
    .i_clear    (wdog_clear),
    .i_psa      (option_q[rcw_pkg::OPT_PSA]),
    .i_ratio    (option_q[rcw_pkg::OPT_RATIO_LSB +: rcw_pkg::RATIO_W]),
    .o_timeout  (wdog_timeout)
  );

  // Configuration word is loaded only from the programming port.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cfg_q <= rcw_pkg::CFG_ERASED;
    end else if (i_prog_cfg_wr && (state_q == rcw_pkg::st_hold)) begin
      cfg_q <= i_prog_cfg_wdata[rcw_pkg::CFG_IMPL_W-1:0];
    end
  end

  // Unimplemented configuration bits always read back as zero.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prog_cfg_rdata <= '0;
    end else begin
      o_prog_cfg_rdata <= {{(rcw_pkg::CFG_W - rcw_pkg::CFG_IMPL_W){1'b0}}, cfg_q};
    end
  end

  // Low block and the calibration location stay readable whatever the protection.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prog_rd_allowed <= 1'b0;
    end else begin
      o_prog_rd_allowed <= cfg_q[rcw_pkg::CFG_CODE_PROT]
                         || (i_prog_rd_addr < rcw_pkg::PROG_OPEN_LIMIT)
                         || (i_prog_rd_addr == rcw_pkg::PROG_LAST_ADDR);
    end
  end

  // Core state: held in reset, running or asleep.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= rcw_pkg::st_hold;
    end else begin
      case (state_q)
        rcw_pkg::st_hold: begin
          if (release_now) begin
            state_q <= rcw_pkg::st_run;
          end
        end
        rcw_pkg::st_run: begin
          if (reset_evt) begin
            state_q <= rcw_pkg::st_hold;
          end else if (i_sleep_instr) begin
            state_q <= rcw_pkg::st_sleep;
          end
        end
        rcw_pkg::st_sleep: begin
          if (reset_evt) begin
            state_q <= rcw_pkg::st_hold;
          end
        end
        default: begin
          state_q <= rcw_pkg::st_hold;
        end
      endcase
    end
  end

  // The processor is kept in reset for as long as the delay timer runs.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_cpu_reset <= 1'b1;
    end else begin
      o_cpu_reset <= (state_q == rcw_pkg::st_hold) && !release_now
                   || reset_evt;
    end
  end

  // The main oscillator driver is off only while asleep.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_osc_driver_on <= 1'b1;
    end else if (in_run && i_sleep_instr && !reset_evt) begin
      o_osc_driver_on <= 1'b0;
    end else if (reset_evt) begin
      o_osc_driver_on <= 1'b1;
    end
  end

  // Ordinary registers elsewhere restore on every reset except a Sleep resumption by the reset pin or the watchdog.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_regs_reset <= 1'b1;
    end else begin
      o_regs_reset <= reset_evt && !resume;
    end
  end

  // Program counter sits at the last location during reset, then the core wraps to zero.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pc_low  <= rcw_pkg::PC_LOW_RST;
      o_pc_load <= 1'b0;
    end else begin
      o_pc_load <= release_now;
      if (reset_evt) begin
        o_pc_low <= rcw_pkg::PC_LOW_RST;
      end
    end
  end

  // First fetch after release is the calibration literal load into the accumulator.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_accum_value <= rcw_pkg::ZERO_BYTE;
      o_accum_load  <= 1'b0;
    end else begin
      o_accum_load <= release_now;
      if (release_now) begin
        o_accum_value <= i_cal_literal;
      end
    end
  end

  // Reset cause flags; hardware events win over a software write in the same cycle.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      status_q                        <= rcw_pkg::ZERO_BYTE;
      status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b1;
      status_q[rcw_pkg::ST_PWRDOWN_N] <= 1'b1;
    end else if (reset_evt && in_sleep) begin
      status_q[rcw_pkg::ST_PWRDOWN_N] <= 1'b0;
      if (ext_low) begin
        status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b1;
        status_q[rcw_pkg::ST_PIN_WAKE]  <= 1'b0;
      end else if (wdog_timeout) begin
        status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b0;
        status_q[rcw_pkg::ST_PIN_WAKE]  <= 1'b0;
      end else begin
        status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b1;
        status_q[rcw_pkg::ST_PIN_WAKE]  <= 1'b1;
      end
    end else if (reset_evt && in_run) begin
      if (!ext_low) begin
        status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b0;
        status_q[rcw_pkg::ST_PIN_WAKE]  <= 1'b0;
      end
    end else if (in_run && i_sleep_instr) begin
      status_q[rcw_pkg::ST_TIMEOUT_N] <= 1'b1;
      status_q[rcw_pkg::ST_PWRDOWN_N] <= 1'b0;
    end else if (sw_wr_status) begin
      status_q <= (i_reg_wdata & rcw_pkg::STATUS_SW_MASK)
                | (status_q & ~rcw_pkg::STATUS_SW_MASK);
    end
  end

  // Trim keeps its value across every reset except power-on.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      trim_q <= rcw_pkg::OSC_TRIM_POR;
    end else if (sw_wr_trim) begin
      trim_q <= i_reg_wdata;
    end
  end

  // Converter control and prescale option return to their values on every reset.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || reset_evt) begin
      conv_q   <= rcw_pkg::CONV_CTRL_RST;
      option_q <= rcw_pkg::OPTION_RST;
    end else begin
      if (sw_wr_conv) begin
        conv_q <= i_reg_wdata & rcw_pkg::CONV_CTRL_MASK;
      end
      if (i_option_wr && in_run) begin
        option_q <= i_option_wdata;
      end
    end
  end

  // Register read port; unmapped addresses read zero and the configuration word never appears.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata <= rcw_pkg::ZERO_BYTE;
    end else begin
      case (i_reg_addr)
        rcw_pkg::ADDR_STATUS:    o_reg_rdata <= status_q;
        rcw_pkg::ADDR_OSC_TRIM:  o_reg_rdata <= trim_q;
        rcw_pkg::ADDR_CONV_CTRL: o_reg_rdata <= conv_q;
        default:                 o_reg_rdata <= rcw_pkg::ZERO_BYTE;
      endcase
    end
  end

  assign o_status    = status_q;
  assign o_osc_trim  = trim_q;
  assign o_option    = option_q;
  assign o_conv_ctrl = conv_q;

endmodule

// [tb/reset_pin_driver.sv]
// Behavioural model of the board circuit that drives the external reset pin.
`timescale 1ns/1ps
module reset_pin_driver (
  input  wire logic i_pull_low,
  output logic      o_pin
);
  // A released line rests high through the board resistor, never at a stale level.
  assign o_pin = i_pull_low ? 1'b0 : 1'b1;
endmodule

// [tb/rcw_asserts.sv]
// Concurrent checks on the ports of the reset, configuration and watchdog unit.
`timescale 1ns/1ps
module rcw_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire logic        i_shared_input_pin,
  input wire logic        i_sleep_instr,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  i_prog_rd_addr,
  input wire logic [11:0] o_prog_cfg_rdata,
  input wire logic        o_prog_rd_allowed,
  input wire logic        o_cpu_reset,
  input wire logic [7:0]  o_pc_low,
  input wire logic        o_pc_load,
  input wire logic        o_accum_load,
  input wire logic [7:0]  o_status,
  input wire logic [7:0]  o_osc_trim,
  input wire logic        o_osc_driver_on,
  input wire logic        o_shared_pin_is_gpio,
  input wire logic        o_ext_reset_pullup_en,
  input wire logic        o_code_protect_on,
  input wire logic        o_wdog_enabled
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_release;
    o_cpu_reset ##1 !o_cpu_reset;
  endsequence
  sequence s_sleep_enter;
    i_sleep_instr && o_osc_driver_on && !o_cpu_reset && i_shared_input_pin;
  endsequence
  a_cfg_upper_zero: assert property (o_prog_cfg_rdata[11:5] == 7'h00)
    else $error("config upper bits not zero");
  a_pullup_needs_pin: assert property (o_ext_reset_pullup_en |-> !o_shared_pin_is_gpio)
    else $error("pull-up on while pin is gpio");
  a_ext_reset_taken: assert property (!o_shared_pin_is_gpio && !i_shared_input_pin && !o_cpu_reset
    |=> o_cpu_reset)
    else $error("external reset not taken");
  a_wdog_stays_off: assert property (!o_wdog_enabled && i_shared_input_pin && o_osc_driver_on
    && !o_cpu_reset |=> !o_cpu_reset)
    else $error("reset with watchdog disabled");
  a_trim_write: assert property (i_reg_wr && i_reg_addr == rcw_pkg::ADDR_OSC_TRIM
    && o_osc_driver_on && !o_cpu_reset |=> o_osc_trim == $past(i_reg_wdata))
    else $error("trim write lost");
  a_sleep_flags: assert property (s_sleep_enter |=> o_status[4] && !o_status[3]
    && !o_osc_driver_on)
    else $error("sleep entry flags wrong");
  a_release_vector: assert property (s_release |-> o_pc_load && o_pc_low == 8'hff)
    else $error("release without vector load");
  a_accum_pair: assert property (o_accum_load == o_pc_load)
    else $error("accumulator load not paired");
  a_rd_vector: assert property (i_prog_rd_addr == 8'hff |=> o_prog_rd_allowed)
    else $error("last location not readable");
  a_cp_off_read: assert property (!$past(i_srst) && $past(!o_code_protect_on)
    |-> o_prog_rd_allowed)
    else $error("read refused with protection off");
endmodule

bind reset_config_watchdog_unit rcw_asserts u_chk (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_shared_input_pin(i_shared_input_pin),
  .i_sleep_instr(i_sleep_instr), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_prog_rd_addr(i_prog_rd_addr),
  .o_prog_cfg_rdata(o_prog_cfg_rdata), .o_prog_rd_allowed(o_prog_rd_allowed),
  .o_cpu_reset(o_cpu_reset), .o_pc_low(o_pc_low), .o_pc_load(o_pc_load),
  .o_accum_load(o_accum_load), .o_status(o_status), .o_osc_trim(o_osc_trim),
  .o_osc_driver_on(o_osc_driver_on), .o_shared_pin_is_gpio(o_shared_pin_is_gpio),
  .o_ext_reset_pullup_en(o_ext_reset_pullup_en), .o_code_protect_on(o_code_protect_on),
  .o_wdog_enabled(o_wdog_enabled));

// [tb/test_reset_config_watchdog_unit.sv]
// Self-checking bench for the reset, configuration and watchdog unit.
`timescale 1ns/1ps
module test_reset_config_watchdog_unit;
  localparam int         POR_N = 64;
  localparam int         SUB_N = 2500;
  localparam logic [7:0] CAL   = 8'hb6;
  logic clk = 1'b0, srst = 1'b1, pull_low = 1'b1, pin, sleep_i = 1'b0, clr_i = 1'b0;
  logic pchg = 1'b0, reg_wr = 1'b0, opt_wr = 1'b0, cfg_wr = 1'b0, saw_rr = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, opt_wdata = 8'h00, rd_addr = 8'h00, d;
  logic [11:0] cfg_wdata = 12'h000, cfg_rdata;
  logic rd_ok, cpu_rst, regs_rst, pc_load, acc_load, osc8, osc_on, gpio, pu_en, cp_on, wd_en;
  logic [7:0]  rdata, pc_low, acc, status, trim, option, conv;
  int          num_errors = 0;
  int          n_checks = 0;
  int          n;

  always #2 clk = ~clk;
  always @(posedge clk) if (regs_rst === 1'b1) saw_rr <= 1'b1;

  reset_pin_driver u_pin (.i_pull_low(pull_low), .o_pin(pin));
  reset_config_watchdog_unit #(.DRT_POR_CYCLES(POR_N), .WDOG_BASE_CYCLES(32)) DUT (
    .i_core_clk(clk), .i_srst(srst), .i_shared_input_pin(pin), .i_sleep_instr(sleep_i),
    .i_wdog_clear_instr(clr_i), .i_pin_change(pchg), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .i_option_wr(opt_wr),
    .i_option_wdata(opt_wdata), .i_prog_cfg_wr(cfg_wr), .i_prog_cfg_wdata(cfg_wdata),
    .o_prog_cfg_rdata(cfg_rdata), .i_prog_rd_addr(rd_addr), .o_prog_rd_allowed(rd_ok),
    .i_cal_literal(CAL), .o_cpu_reset(cpu_rst), .o_regs_reset(regs_rst), .o_pc_low(pc_low),
    .o_pc_load(pc_load), .o_accum_value(acc), .o_accum_load(acc_load), .o_status(status),
    .o_osc_trim(trim), .o_option(option), .o_conv_ctrl(conv), .o_osc_8mhz_sel(osc8),
    .o_osc_driver_on(osc_on), .o_shared_pin_is_gpio(gpio), .o_ext_reset_pullup_en(pu_en),
    .o_code_protect_on(cp_on), .o_wdog_enabled(wd_en));

  task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Counts edges until the release pulse (sel=1) or the reset level (sel=0) shows.
  task wait_hi(input bit sel, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? pc_load : cpu_rst) !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1 cnt++;
    end
    if (cnt >= lim) begin
      num_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up;
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk) reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = rdata;
  endtask
  task probe(input logic [7:0] a, input logic e);
    @(posedge clk) rd_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(rd_ok, e, "readout");
  endtask
  task ext_pulse;
    @(posedge clk) pull_low <= 1'b1;
    @(posedge clk) pull_low <= 1'b0;
  endtask
  task go_sleep;
    @(posedge clk) sleep_i <= 1'b1;
    @(posedge clk) sleep_i <= 1'b0;
    @(posedge clk);
    #1 chk({status[4:3], osc_on}, 3'b100, "sleep entry");
  endtask
  task opt_write(input logic [7:0] v);
    @(posedge clk) {opt_wr, opt_wdata, clr_i} <= {1'b1, v, 1'b1};
    @(posedge clk) {opt_wr, clr_i} <= 2'b00;
  endtask

  task t_power_on;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk(cpu_rst, 1'b1, "held while pin low");
    chk({trim, status[4:3]}, {8'hfe, 2'b11}, "trim and flags");
    chk({option, conv}, 12'hfcc, "option and converter");
    chk(cfg_rdata, 12'h01f, "erased config");
    @(posedge clk) {cfg_wr, cfg_wdata} <= {1'b1, 12'hff3};
    @(posedge clk) cfg_wr <= 1'b0;
    @(posedge clk);
    #1 chk(cfg_rdata, 12'h013, "config upper bits");
    chk({gpio, cp_on, wd_en, pu_en, osc8}, 5'b01001, "config fields");
    @(posedge clk) pull_low <= 1'b0;
    wait_hi(1'b1, 500, n);
    chk(n >= POR_N - 2 && n <= POR_N + 4, 1'b1, "power-on delay");
    chk({pc_low, acc_load}, {8'hff, 1'b1}, "vector");
    chk(acc & rcw_pkg::ACCUM_CAL_MASK, CAL & rcw_pkg::ACCUM_CAL_MASK, "calibration");
    $display("power-on test done");
  endtask
  task t_regs;
    probe(8'h3f, 1'b1);
    probe(8'h40, 1'b0);
    probe(8'hff, 1'b1);
    repeat (100) @(posedge clk);
    #1 chk(cpu_rst, 1'b0, "watchdog disabled");
    wr_reg(rcw_pkg::ADDR_OSC_TRIM, 8'h5a);
    rd_reg(rcw_pkg::ADDR_OSC_TRIM);
    chk(d, 8'h5a, "trim readback");
    wr_reg(rcw_pkg::ADDR_STATUS, 8'h00);
    rd_reg(rcw_pkg::ADDR_STATUS);
    chk(d, 8'h18, "flags read only");
    wr_reg(rcw_pkg::ADDR_CONV_CTRL, 8'hff);
    rd_reg(rcw_pkg::ADDR_CONV_CTRL);
    chk(d, 8'hcf, "converter bits");
    rd_reg(8'h09);
    chk(d, 8'h00, "unmapped read");
    $display("register test done");
  endtask
  task t_ext_sleep;
    saw_rr = 1'b0;
    ext_pulse;
    @(posedge clk);
    #1 chk(cpu_rst, 1'b1, "external reset taken");
    wait_hi(1'b1, 3000, n);
    chk(n >= SUB_N - 2 && n <= SUB_N + 4, 1'b1, "short delay");
    chk({saw_rr, status[7], status[4:3]}, 4'b1011, "run external");
    chk(trim, 8'h5a, "trim kept");
    chk(conv, 8'hcc, "converter restored");
    go_sleep;
    saw_rr = 1'b0;
    ext_pulse;
    wait_hi(1'b1, 3000, n);
    chk({saw_rr, status[7], status[4:3]}, 4'b0010, "sleep external");
    go_sleep;
    saw_rr = 1'b0;
    @(posedge clk) pchg <= 1'b1;
    @(posedge clk) pchg <= 1'b0;
    wait_hi(1'b1, 3000, n);
    chk({saw_rr, status[7], status[4:3]}, 4'b1110, "pin wake");
    $display("reset source test done");
  endtask
  task t_watchdog;
    @(posedge clk) pull_low <= 1'b1;
    @(posedge clk) {cfg_wr, cfg_wdata} <= {1'b1, 12'h017};
    @(posedge clk) {cfg_wr, pull_low} <= 2'b00;
    wait_hi(1'b1, 3000, n);
    opt_write(8'h00);
    repeat (6) begin
      repeat (20) @(posedge clk);
      clr_i <= 1'b1;
      @(posedge clk) clr_i <= 1'b0;
    end
    #1 chk({wd_en, cpu_rst}, 2'b10, "cleared in time");
    opt_write(8'h0a);
    wait_hi(1'b0, 400, n);
    chk(n >= 124 && n <= 134, 1'b1, "prescaled period");
    wait_hi(1'b1, 3000, n);
    chk({status[4], option}, {1'b0, 8'hff}, "run watchdog");
    go_sleep;
    wait_hi(1'b0, 5000, n);
    chk(n >= 4088 && n <= 4100, 1'b1, "sleep period");
    wait_hi(1'b1, 3000, n);
    chk(status[4:3], 2'b00, "sleep watchdog");
    $display("watchdog test done");
  endtask

  initial begin
    t_power_on;
    t_regs;
    t_ext_sleep;
    t_watchdog;
    wrap_up;
  end
endmodule
